// [src/iag_pkg.sv]
package iag_pkg;

    // ------------------------------------------------------------
    // Widths and instruction field positions
    // ------------------------------------------------------------
    localparam int PTR_W         = 16;
    localparam int INSTR_W       = 16;
    localparam int OPCODE_HI     = 15;
    localparam int OPCODE_LO     = 8;
    localparam int MODE_BIT      = 7;
    localparam int OP_HI         = 6;
    localparam int OP_LO         = 4;
    localparam int UPDATE_BIT    = 3;
    localparam int NEXT_HI       = 2;
    localparam int NEXT_LO       = 0;
    localparam int NEXT_W        = 3;
    localparam int NUM_PTRS      = 8;

    // ------------------------------------------------------------
    // Register map, byte addresses on the APB port
    // ------------------------------------------------------------
    localparam int APB_ADDR_W    = 8;
    localparam int DATA_W        = 32;
    localparam int WORD_SHIFT    = 2;
    localparam logic [7:0] OFF_PTR_BASE  = 8'h00;
    localparam logic [7:0] OFF_PTR_LAST  = 8'h1c;
    localparam logic [7:0] OFF_STEP      = 8'h20;
    localparam logic [7:0] OFF_COMPARE   = 8'h24;
    localparam logic [7:0] OFF_MODE      = 8'h28;
    localparam logic [7:0] OFF_SELECT    = 8'h2c;
    localparam logic [7:0] OFF_LAST_ADDR = 8'h30;

    // Field positions inside the mode and select registers.
    localparam int MODE_LEGACY_POS = 0;
    localparam int SEL_ACTIVE_LO   = 0;
    localparam int SEL_PREV_LO     = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PTR_W-1:0]  PTR_RST    = 16'h0000;
    localparam logic [NEXT_W-1:0] SEL_RST    = 3'h0;
    localparam logic              LEGACY_RST = 1'b0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Encoding is {use step amount, step up, step down}.
    typedef enum logic [2:0] {
        OP_HOLD     = 3'b000,
        OP_DEC_ONE  = 3'b001,
        OP_INC_ONE  = 3'b010,
        OP_RESERVED = 3'b011,
        OP_SUB_REV  = 3'b100,
        OP_SUB_STEP = 3'b101,
        OP_ADD_STEP = 3'b110,
        OP_ADD_REV  = 3'b111
    } ptr_op_t;

    typedef struct packed {
        logic [7:0]        opcode;
        logic              indirect;
        ptr_op_t           op;
        logic              update;
        logic [NEXT_W-1:0] next_ptr;
    } instr_fields_t;

    typedef struct packed {
        logic             valid;
        logic             indirect;
        logic [7:0]       opcode;
        logic [PTR_W-1:0] addr;
    } mem_req_t;

endpackage

// [src/instr_field_decode.sv]
`timescale 1ns/10ps
module instr_field_decode
    import iag_pkg::*;
(
    input  wire logic [INSTR_W-1:0] word_in,
    output instr_fields_t           fields_out
);

    // ------------------------------------------------------------
    // Field split
    // ------------------------------------------------------------
    always_comb begin
        fields_out.opcode   = word_in[OPCODE_HI:OPCODE_LO];
        fields_out.indirect = word_in[MODE_BIT];
        fields_out.op       = ptr_op_t'(word_in[OP_HI:OP_LO]);
        fields_out.update   = word_in[UPDATE_BIT];
        fields_out.next_ptr = word_in[NEXT_HI:NEXT_LO];
    end

endmodule // instr_field_decode

// [src/pointer_math_unit.sv]
`timescale 1ns/10ps
module pointer_math_unit
    import iag_pkg::*;
#(
    parameter int W = PTR_W
) (
    input  wire logic [W-1:0] cur_in,
    input  wire logic [W-1:0] step_in,
    input  ptr_op_t           op_in,
    output logic      [W-1:0] next_out
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (W < 2) begin : g_bad_width
        $error("pointer_math_unit: width must be at least 2");
    end

    // ------------------------------------------------------------
    // Bit reversal of operands and of the reversed-domain result
    // ------------------------------------------------------------
    logic [W-1:0] rev_cur;
    logic [W-1:0] rev_step;
    logic [W-1:0] rev_sum;
    logic [W-1:0] rev_diff;
    logic [W-1:0] back_sum;
    logic [W-1:0] back_diff;

    // Carries run toward bit 0 when the operands are mirrored first.
    for (genvar i = 0; i < W; i++) begin : g_rev
        assign rev_cur[i]   = cur_in[W-1-i];
        assign rev_step[i]  = step_in[W-1-i];
        assign back_sum[i]  = rev_sum[W-1-i];
        assign back_diff[i] = rev_diff[W-1-i];
    end

    assign rev_sum  = rev_cur + rev_step;
    assign rev_diff = rev_cur - rev_step;

    // ------------------------------------------------------------
    // Operation select, unsigned and wrapping at the pointer width
    // ------------------------------------------------------------
    always_comb begin
        case (op_in)
            OP_HOLD:     next_out = cur_in;
            OP_DEC_ONE:  next_out = cur_in - W'(1);
            OP_INC_ONE:  next_out = cur_in + W'(1);
            OP_SUB_REV:  next_out = back_diff;
            OP_SUB_STEP: next_out = cur_in - step_in;
            OP_ADD_STEP: next_out = cur_in + step_in;
            OP_ADD_REV:  next_out = back_sum;
            // The reserved code leaves the pointer alone.
            default:     next_out = cur_in;
        endcase
    end

endmodule // pointer_math_unit

// [src/indirect_address_generator.sv]
// Functional notes
// - No-modify option: address is current pointer, pointer kept.
// - Step-by-one options: address is current pointer, then plus or minus 1.
// - Indexed options: address is current pointer, then plus or minus step.
// - Bit-reversed options add or subtract step with carries reversed.
// - Pointer update lands in the decode cycle, after address use.
// - Indirect instruction may also change the active pointer.
// - Legacy bit low: pointer zero writes also load step and compare.
// - Reset clears the legacy index mode bit.
// - Upper byte is opcode; lower byte holds addressing fields.
// - Bit 7 selects direct (0) or indirect (1) addressing.
// - Use step bit low: steps are by one, step register unused.
// - Use step bit high: steps use step register, normal or reversed.
// - Bit 5 is the increment selector; zero means no increment.
// - Indirect only for instructions with a memory operand.
// - Bit 4 is the decrement selector, by one or by step.
// - Three selection bits encode the eight pointer operations.
// - Update bit loads next pointer field, old select saved.
// - Pointer arithmetic is unsigned 16-bit and wraps.
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
module indirect_address_generator
    import iag_pkg::*;
#(
    parameter int NUM_POINTERS = NUM_PTRS
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  reset_n_in,
    input  wire logic                  instr_valid_in,
    input  wire logic [INSTR_W-1:0]    instr_word_in,
    input  wire logic                  instr_has_operand_in,
    output mem_req_t                   mem_req_out,
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [APB_ADDR_W-1:0] paddr_in,
    input  wire logic [DATA_W-1:0]     pwdata_in,
    output logic      [DATA_W-1:0]     prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    // The next-pointer field is three bits wide, so exactly eight
    // pointers can be addressed.
    if (NUM_POINTERS != (1 << NEXT_W)) begin : g_bad_count
        $error("indirect_address_generator: pointer count must be 8");
    end

    // The field positions must agree with the field widths, or the
    // decoder would hand the math unit a shifted operation code.
    if ((OP_HI - OP_LO + 1) != $bits(ptr_op_t)) begin : g_bad_op_field
        $error("indirect_address_generator: op field width mismatch");
    end
    if ((NEXT_HI - NEXT_LO + 1) != NEXT_W) begin : g_bad_next_field
        $error("indirect_address_generator: next field width mismatch");
    end

    // A pointer must fit in one bus word, and the pointer words must
    // end below the step register, or two registers would share an
    // address.
    if (PTR_W > DATA_W) begin : g_bad_data_width
        $error("indirect_address_generator: pointer wider than bus word");
    end
    if ((NUM_POINTERS << WORD_SHIFT) > int'(OFF_STEP)) begin : g_bad_map
        $error("indirect_address_generator: pointer words overlap map");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [PTR_W-1:0]  ptr_q [NUM_POINTERS];
    logic [PTR_W-1:0]  step_q;
    logic [PTR_W-1:0]  compare_q;
    logic              legacy_q;
    logic [NEXT_W-1:0] active_q;
    logic [NEXT_W-1:0] prev_q;
    mem_req_t          req_q;
    logic              busy_q;
    logic [DATA_W-1:0] rdata_q;

    // ------------------------------------------------------------
    // Instruction decode and pointer math
    // ------------------------------------------------------------
    instr_fields_t     fields;
    logic [PTR_W-1:0]  cur_ptr;
    logic [PTR_W-1:0]  next_ptr;
    logic              take;

    instr_field_decode u_decode (
        .word_in    (instr_word_in),
        .fields_out (fields)
    );

    assign cur_ptr = ptr_q[active_q];

    pointer_math_unit #(
        .W (PTR_W)
    ) u_math (
        .cur_in   (cur_ptr),
        .step_in  (step_q),
        .op_in    (fields.op),
        .next_out (next_ptr)
    );

    // An indirect access is taken only for a decoded instruction in
    // indirect mode that really addresses data memory.
    assign take = instr_valid_in && fields.indirect &&
                  instr_has_operand_in;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic              acc;
    logic              wr_en;
    logic              hit_ptr;
    logic              hit_any;
    logic [NEXT_W-1:0] wr_idx;
    logic [DATA_W-1:0] rd_mux;

    // Access is stalled while an instruction is decoded now or was in
    // the previous cycle, so register writes never race pointer math
    // and read data captured in setup is never stale.
    // The stall has no upper bound: a decoder that issues an
    // instruction every cycle holds the bus off for as long.
    assign pready_out = !instr_valid_in && !busy_q;
    assign acc        = psel_in && penable_in && pready_out;
    assign hit_ptr    = paddr_in <= OFF_PTR_LAST;
    assign wr_idx     = paddr_in[WORD_SHIFT +: NEXT_W];

    always_comb begin
        hit_any = 1'b1;
        rd_mux  = '0;
        if (paddr_in[WORD_SHIFT-1:0] != '0) begin
            hit_any = 1'b0;
        end else if (hit_ptr) begin
            rd_mux[PTR_W-1:0] = ptr_q[wr_idx];
        end else begin
            case (paddr_in)
                OFF_STEP: begin
                    rd_mux[PTR_W-1:0] = step_q;
                end
                OFF_COMPARE: begin
                    rd_mux[PTR_W-1:0] = compare_q;
                end
                OFF_MODE: begin
                    rd_mux[MODE_LEGACY_POS] = legacy_q;
                end
                OFF_SELECT: begin
                    rd_mux[SEL_ACTIVE_LO +: NEXT_W] = active_q;
                    rd_mux[SEL_PREV_LO +: NEXT_W]   = prev_q;
                end
                OFF_LAST_ADDR: begin
                    rd_mux[PTR_W-1:0] = req_q.addr;
                end
                default: begin
                    hit_any = 1'b0;
                end
            endcase
        end
    end

    assign wr_en       = acc && pwrite_in && hit_any;
    assign pslverr_out = psel_in && penable_in && !hit_any;
    assign prdata_out  = rdata_q;

    // ------------------------------------------------------------
    // Pointer zero write detection for the legacy copy
    // ------------------------------------------------------------
    // Hold and the reserved code leave pointer zero untouched, so
    // they do not count as a modification and copy nothing.
    logic              p0_write;
    logic [PTR_W-1:0]  p0_value;

    always_comb begin
        p0_write = 1'b0;
        p0_value = next_ptr;
        if (take && (active_q == '0) && (fields.op != OP_HOLD) &&
            (fields.op != OP_RESERVED)) begin
            p0_write = 1'b1;
        end else if (wr_en && hit_ptr && (wr_idx == '0)) begin
            p0_write = 1'b1;
            p0_value = pwdata_in[PTR_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Auxiliary pointers
    // ------------------------------------------------------------
    // Post-access update: the unmodified value has already been sent
    // out as the address on this same edge.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_POINTERS; i++) begin
                ptr_q[i] <= PTR_RST;
            end
        end else if (take) begin
            ptr_q[active_q] <= next_ptr;
        end else if (wr_en && hit_ptr) begin
            ptr_q[wr_idx] <= pwdata_in[PTR_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Active pointer select and previous pointer buffer
    // ------------------------------------------------------------
    // A bus write sets both fields at once, so software can restore
    // a saved selection in one transfer.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            active_q <= SEL_RST;
            prev_q   <= SEL_RST;
        end else if (take && fields.update) begin
            active_q <= fields.next_ptr;
            prev_q   <= active_q;
        end else if (wr_en && (paddr_in == OFF_SELECT)) begin
            active_q <= pwdata_in[SEL_ACTIVE_LO +: NEXT_W];
            prev_q   <= pwdata_in[SEL_PREV_LO +: NEXT_W];
        end
    end

    // ------------------------------------------------------------
    // Step amount and compare registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            step_q <= PTR_RST;
        end else if (!legacy_q && p0_write) begin
            step_q <= p0_value;
        end else if (wr_en && (paddr_in == OFF_STEP)) begin
            step_q <= pwdata_in[PTR_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            compare_q <= PTR_RST;
        end else if (!legacy_q && p0_write) begin
            compare_q <= p0_value;
        end else if (wr_en && (paddr_in == OFF_COMPARE)) begin
            compare_q <= pwdata_in[PTR_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    // The bit resets low, so the copy into step and compare is live
    // from reset until software sets the bit.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            legacy_q <= LEGACY_RST;
        end else if (wr_en && (paddr_in == OFF_MODE)) begin
            legacy_q <= pwdata_in[MODE_LEGACY_POS];
        end
    end

    // ------------------------------------------------------------
    // Memory request toward the data address bus
    // ------------------------------------------------------------
    // The request is registered: it shows the pointer value as it was
    // before this decode cycle's update, one cycle after the decode.
    // Registering the request costs a cycle of latency but keeps the
    // address bus free of glitches from the pointer mux.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_q <= '0;
        end else begin
            req_q.valid    <= take;
            req_q.indirect <= instr_valid_in && fields.indirect;
            if (instr_valid_in) begin
                req_q.opcode <= fields.opcode;
            end
            if (take) begin
                req_q.addr <= cur_ptr;
            end
        end
    end

    assign mem_req_out = req_q;

    // ------------------------------------------------------------
    // APB read capture and stall tracking
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= instr_valid_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= '0;
        end else if (psel_in) begin
            rdata_q <= rd_mux;
        end
    end

endmodule // indirect_address_generator

// [tb/iag_sva.sv]
`timescale 1ns/10ps
module iag_sva
    import iag_pkg::*;
(
    input wire logic                  sys_clk_in,
    input wire logic                  reset_n_in,
    input wire logic                  instr_valid_in,
    input wire logic [INSTR_W-1:0]    instr_word_in,
    input wire logic                  instr_has_operand_in,
    input wire mem_req_t              mem_req_out,
    input wire logic                  psel_in,
    input wire logic                  penable_in,
    input wire logic                  pwrite_in,
    input wire logic [APB_ADDR_W-1:0] paddr_in,
    input wire logic [DATA_W-1:0]     pwdata_in,
    input wire logic [DATA_W-1:0]     prdata_out,
    input wire logic                  pready_out,
    input wire logic                  pslverr_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    logic acc;
    assign acc = instr_valid_in && instr_word_in[MODE_BIT]
                 && instr_has_operand_in;

    // Indexed steps need the step value, so only steps by one and the no-change codes are traced.
    property p_step_one;
        acc && !instr_word_in[UPDATE_BIT] && !instr_word_in[OP_HI] ##1 acc
        |=> mem_req_out.addr == $past(mem_req_out.addr)
            + (($past(instr_word_in[5:4], 2) == 2'b10) ? 16'h0001 :
               ($past(instr_word_in[5:4], 2) == 2'b01) ? 16'hffff : 16'h0000);
    endproperty

    a_indirect_answer: assert property (
        acc |=> mem_req_out.valid && mem_req_out.indirect)
        else $error("indirect access gave no address");
    a_direct_silent: assert property (
        instr_valid_in && !instr_word_in[MODE_BIT] |=> !mem_req_out.valid)
        else $error("direct instruction gave an address");
    a_operand_needed: assert property (
        instr_valid_in && !instr_has_operand_in |=> !mem_req_out.valid)
        else $error("operand-less instruction gave an address");
    a_opcode_passed: assert property (
        acc |=> mem_req_out.opcode == $past(instr_word_in[15:8]))
        else $error("opcode field not passed on");
    a_valid_cause: assert property (
        mem_req_out.valid |-> $past(acc))
        else $error("address without indirect instruction");
    a_addr_held: assert property (
        !mem_req_out.valid |-> $stable(mem_req_out.addr))
        else $error("address moved without an access");
    a_step_by_one: assert property (p_step_one)
        else $error("step by one gave wrong next address");
    a_bus_stalled: assert property (
        instr_valid_in |-> !pready_out ##1 !pready_out)
        else $error("bus answered while decoding");

    c_back_to_back: cover property (acc ##1 acc ##1 acc);
    c_ptr_reselect: cover property (acc && instr_word_in[UPDATE_BIT]);
    c_direct: cover property (instr_valid_in && !instr_word_in[MODE_BIT]);
endmodule // iag_sva

bind indirect_address_generator iag_sva chk (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
    .instr_has_operand_in(instr_has_operand_in),
    .mem_req_out(mem_req_out), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out));

// [tb/decoder_model.sv]
`timescale 1ns/10ps
module decoder_model
    import iag_pkg::*;
(
    input  wire logic               sys_clk_in,
    output logic                    instr_valid_out,
    output logic      [INSTR_W-1:0] instr_word_out,
    output logic                    instr_has_operand_out
);
    initial begin
        instr_valid_out = 1'b0;
        instr_word_out = 16'h0000;
        instr_has_operand_out = 1'b0;
    end

    // Calls chain back to back, one instruction per cycle.
    task automatic send(input logic [INSTR_W-1:0] w, input logic has_op);
        @(posedge sys_clk_in);
        instr_valid_out <= 1'b1;
        instr_word_out <= w;
        instr_has_operand_out <= has_op;
    endtask

    // Released lines show the inverse of the last word, never a stale copy.
    task automatic idle();
        @(posedge sys_clk_in);
        instr_valid_out <= 1'b0;
        instr_word_out <= ~instr_word_out;
        instr_has_operand_out <= ~instr_has_operand_out;
    endtask
endmodule // decoder_model

// [tb/indirect_address_generator_test.sv]
`timescale 1ns/10ps
module indirect_address_generator_test
    import iag_pkg::*;
;
    logic                  sys_clk;
    logic                  reset_n;
    logic                  instr_valid;
    logic [INSTR_W-1:0]    instr_word;
    logic                  has_operand;
    mem_req_t              mem_req;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [DATA_W-1:0]     pwdata;
    logic [DATA_W-1:0]     prdata;
    logic                  pready;
    logic                  pslverr;
    int                    fail_count = 0;
    int                    total_checks = 0;
    int                    cycles = 0;

    indirect_address_generator dut (
        .sys_clk_in(sys_clk), .reset_n_in(reset_n),
        .instr_valid_in(instr_valid), .instr_word_in(instr_word),
        .instr_has_operand_in(has_operand), .mem_req_out(mem_req),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr));

    decoder_model dec (
        .sys_clk_in(sys_clk), .instr_valid_out(instr_valid),
        .instr_word_out(instr_word), .instr_has_operand_out(has_operand));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {16'h0000, d}, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(r, exp);
    endtask

    function automatic logic [15:0] rev(input logic [15:0] v);
        for (int i = 0; i < 16; i++)
            rev[i] = v[15-i];
    endfunction

    function automatic logic [15:0] step_ref(input logic [15:0] c,
                                             input logic [15:0] s,
                                             input logic [2:0] op);
        case (op)
            3'b001: return c - 16'h0001;
            3'b010: return c + 16'h0001;
            3'b100: return rev(rev(c) - rev(s));
            3'b101: return c - s;
            3'b110: return c + s;
            3'b111: return rev(rev(c) + rev(s));
            default: return c;
        endcase
    endfunction

    function automatic logic [15:0] iw(input logic [2:0] op,
                                       input logic u, input logic [2:0] n);
        return {8'h3a, 1'b1, op, u, n};
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic        e;
        logic [15:0] cur;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd_chk(OFF_MODE, 32'h0000_0000);
        rd_chk(OFF_SELECT, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000, r, e);
        check({31'h0, e}, 32'h0000_0001);
        $display("test reset done");
        // Legacy copy is off here so pointer one can be stepped alone.
        wr(OFF_MODE, 16'h0001);
        wr(OFF_STEP, 16'h0010);
        wr(OFF_SELECT, 16'h0001);
        cur = 16'hfff8;
        wr(OFF_PTR_BASE + 8'h04, cur);
        for (int op = 0; op < 8; op++) begin
            dec.send(iw(3'(op), 1'b0, 3'h0), 1'b1);
            dec.idle();
            rd_chk(OFF_LAST_ADDR, {16'h0000, cur});
            cur = step_ref(cur, 16'h0010, 3'(op));
            rd_chk(OFF_PTR_BASE + 8'h04, {16'h0000, cur});
        end
        $display("test op table done");
        dec.send({8'h3a, 1'b0, 7'h25}, 1'b1);
        dec.send(iw(3'b010, 1'b1, 3'h6), 1'b0);
        dec.idle();
        rd_chk(OFF_PTR_BASE + 8'h04, {16'h0000, cur});
        rd_chk(OFF_SELECT, 32'h0000_0001);
        $display("test refusals done");
        dec.send(iw(3'b000, 1'b1, 3'h5), 1'b1);
        dec.send(iw(3'b010, 1'b0, 3'h0), 1'b1);
        dec.send(iw(3'b010, 1'b0, 3'h0), 1'b1);
        dec.send(iw(3'b011, 1'b0, 3'h0), 1'b1);
        dec.send(iw(3'b001, 1'b0, 3'h0), 1'b1);
        dec.idle();
        rd_chk(OFF_SELECT, 32'h0000_0015);
        rd_chk(OFF_PTR_BASE + 8'h14, 32'h0000_0001);
        $display("test reselect done");
        wr(OFF_MODE, 16'h0000);
        wr(OFF_SELECT, 16'h0000);
        wr(OFF_PTR_BASE, 16'h0040);
        rd_chk(OFF_STEP, 32'h0000_0040);
        rd_chk(OFF_COMPARE, 32'h0000_0040);
        dec.send(iw(3'b110, 1'b0, 3'h0), 1'b1);
        dec.idle();
        rd_chk(OFF_PTR_BASE, 32'h0000_0080);
        rd_chk(OFF_STEP, 32'h0000_0080);
        rd_chk(OFF_COMPARE, 32'h0000_0080);
        $display("test legacy copy done");
        final_report();
    end
endmodule // indirect_address_generator_test
